// ### isolated_fast_serial_link.sv
// Isolated fast serial link: user-side channels A/B joined to a four-wire serial link
//
// Functional notes
// - Any channel in fast serial mode switches channel B pins to the link.
// - Fast serial mode enables only from config bits loaded after reset.
// - Mode 10 holds link idle (no sends, clear-to-send low); data still accepted; mode 0 resumes.
// - An outgoing frame starts with the line driven low.
// - No outgoing frame starts while an incoming frame is in progress.
// - Outgoing data bits follow the start bit, least significant first.
// - Last outgoing bit names source channel: zero for A, one for B.
// - A received start bit drops clear-to-send at the next rising edge.
// - Eight received data bits follow the start bit, least significant first.
// - Target bit zero delivers to A if A enabled, else to B.
// - Target bit one delivers to B if B enabled, else to A.
// - With neither channel in fast serial mode the whole function stays off.
// - Clear-to-send stays low until another byte can be accepted.
`timescale 1ns/1ps
`include "iso_link_cfg.svh"

module isolated_fast_serial_link
(
	// System clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Configuration read from nonvolatile memory
	input wire logic cfg_load,
	input wire logic cfg_a_fast,
	input wire logic cfg_b_fast,
	// Mode-select command
	input wire logic mode_wr,
	input wire logic [7:0] mode_val,
	// Bytes to send out on the link
	input wire logic tx_valid,
	output logic tx_ready,
	input wire iso_link_pkg::byte_t tx_data,
	input wire logic tx_chan,
	// Bytes received for channel A
	output logic rx_a_valid,
	input wire logic rx_a_ready,
	output iso_link_pkg::byte_t rx_a_data,
	// Bytes received for channel B
	output logic rx_b_valid,
	input wire logic rx_b_ready,
	output iso_link_pkg::byte_t rx_b_data,
	// Status
	output logic link_pins_on_b,
	output logic link_held,
	// Link pins
	input wire logic link_clock_in,
	input wire logic link_serial_in,
	output logic link_serial_out,
	output logic link_clear_to_send
);
	import iso_link_pkg::*;

	logic chan_a_fast;
	logic chan_b_fast;
	logic any_fast;
	logic run_meta;
	logic run_sync;
	logic link_rst_meta;
	logic link_rst_b;
	// System-side send holding word
	logic tx_full;
	logic tx_issued;
	byte_t tx_word;
	logic tx_src;
	logic tx_req_tgl;
	logic tx_ack_meta;
	logic tx_ack_sync;
	logic tx_ack_seen;
	// Link-side send
	logic tx_req_meta;
	logic tx_req_sync;
	logic tx_ack_tgl;
	logic tx_pending;
	logic launch;
	tx_state_e tx_state;
	logic [2:0] tx_idx;
	byte_t tx_frame;
	logic tx_frame_src;
	// Link-side receive
	rx_state_e rx_state;
	logic [2:0] rx_idx;
	byte_t rx_shift;
	byte_t rx_word;
	logic rx_target_channel_bit;
	logic rx_req_tgl;
	logic rx_ack_meta;
	logic rx_ack_sync;
	logic rx_ack_seen;
	logic rx_accept;
	logic rx_busy;
	// System-side receive
	logic rx_req_meta;
	logic rx_req_sync;
	logic rx_req_seen;
	logic rx_new;
	logic rx_ack_tgl;
	logic rx_to_b;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			chan_a_fast <= `FAST_EN_RST;
			chan_b_fast <= `FAST_EN_RST;
		end
		else if (cfg_load)
		begin
			chan_a_fast <= cfg_a_fast;
			chan_b_fast <= cfg_b_fast;
		end
	end

	assign any_fast = chan_a_fast | chan_b_fast;
	assign link_pins_on_b = any_fast;

	// Other mode values leave the hold state alone
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			link_held <= `HOLD_RST;
		else if (mode_wr && mode_val == `MODE_HOLD_VAL)
			link_held <= 1'b1;
		else if (mode_wr && mode_val == `MODE_RUN_VAL)
			link_held <= 1'b0;
	end

	// Held words still enter; they wait here until the hold is lifted
	assign tx_ready = any_fast && !tx_full;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_full <= 1'b0;
			tx_issued <= 1'b0;
			tx_word <= `BYTE_RST;
			tx_src <= `SRC_CHAN_A;
			tx_req_tgl <= `TGL_RST;
			tx_ack_seen <= `TGL_RST;
		end
		else if (tx_ack_sync != tx_ack_seen)
		begin
			tx_ack_seen <= tx_ack_sync;
			tx_full <= 1'b0;
			tx_issued <= 1'b0;
		end
		else if (tx_valid && tx_ready)
		begin
			tx_full <= 1'b1;
			tx_word <= tx_data;
			tx_src <= tx_chan;
		end
		else if (tx_full && !tx_issued && !link_held)
		begin
			tx_req_tgl <= ~tx_req_tgl;
			tx_issued <= 1'b1;
		end
	end

	// Event crossings from the link domain
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_ack_meta <= `TGL_RST;
			tx_ack_sync <= `TGL_RST;
			rx_req_meta <= `TGL_RST;
			rx_req_sync <= `TGL_RST;
		end
		else
		begin
			tx_ack_meta <= tx_ack_tgl;
			tx_ack_sync <= tx_ack_meta;
			rx_req_meta <= rx_req_tgl;
			rx_req_sync <= rx_req_meta;
		end
	end

	assign rx_new = rx_req_sync != rx_req_seen;
	// Fallback to the other channel when the named one is not in fast mode
	assign rx_to_b = rx_target_channel_bit ? chan_b_fast : !chan_a_fast;

	// Only one byte is ever outstanding, so new data and a take never collide
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_req_seen <= `TGL_RST;
			rx_ack_tgl <= `TGL_RST;
			rx_a_valid <= 1'b0;
			rx_b_valid <= 1'b0;
			rx_a_data <= `BYTE_RST;
			rx_b_data <= `BYTE_RST;
		end
		else if (rx_new)
		begin
			rx_req_seen <= rx_req_sync;
			if (rx_to_b)
			begin
				rx_b_valid <= 1'b1;
				rx_b_data <= rx_word;
			end
			else
			begin
				rx_a_valid <= 1'b1;
				rx_a_data <= rx_word;
			end
		end
		else if ((rx_a_valid && rx_a_ready) || (rx_b_valid && rx_b_ready))
		begin
			rx_a_valid <= 1'b0;
			rx_b_valid <= 1'b0;
			rx_ack_tgl <= ~rx_ack_tgl;
		end
	end

	// Link domain, clocked only by the far end
	always_ff @(posedge link_clock_in or negedge rst_b)
	begin
		if (!rst_b)
		begin
			link_rst_meta <= 1'b0;
			link_rst_b <= 1'b0;
		end
		else
		begin
			link_rst_meta <= 1'b1;
			link_rst_b <= link_rst_meta;
		end
	end

	always_ff @(posedge link_clock_in or negedge link_rst_b)
	begin
		if (!link_rst_b)
		begin
			run_meta <= 1'b0;
			run_sync <= 1'b0;
			tx_req_meta <= `TGL_RST;
			tx_req_sync <= `TGL_RST;
			rx_ack_meta <= `TGL_RST;
			rx_ack_sync <= `TGL_RST;
		end
		else
		begin
			run_meta <= any_fast && !link_held;
			run_sync <= run_meta;
			tx_req_meta <= tx_req_tgl;
			tx_req_sync <= tx_req_meta;
			rx_ack_meta <= rx_ack_tgl;
			rx_ack_sync <= rx_ack_meta;
		end
	end

	assign tx_pending = tx_req_sync != tx_ack_tgl;
	assign rx_accept = rx_state == RX_IDLE && link_clear_to_send && link_serial_in == `START_BIT;
	assign rx_busy = rx_accept || rx_state == RX_DATA || rx_state == RX_TARGET_CHANNEL_BIT;
	assign launch = tx_state == TX_IDLE && tx_pending && run_sync && !rx_busy;

	// A stalled link clock simply freezes the frame in place
	always_ff @(posedge link_clock_in or negedge link_rst_b)
	begin
		if (!link_rst_b)
		begin
			tx_state <= TX_IDLE;
			tx_idx <= `FIRST_DATA_IDX;
			tx_frame <= `BYTE_RST;
			tx_frame_src <= `SRC_CHAN_A;
			tx_ack_tgl <= `TGL_RST;
			link_serial_out <= `LINE_IDLE;
		end
		else
		begin
			case (tx_state)
				TX_IDLE:
				begin
					link_serial_out <= `LINE_IDLE;
					if (launch)
					begin
						tx_frame <= tx_word;
						tx_frame_src <= tx_src;
						tx_idx <= `FIRST_DATA_IDX;
						link_serial_out <= `START_BIT;
						tx_state <= TX_DATA;
					end
				end
				TX_DATA:
				begin
					link_serial_out <= tx_frame[tx_idx];
					tx_idx <= tx_idx + 3'h1;
					if (tx_idx == `LAST_DATA_IDX)
						tx_state <= TX_SRC;
				end
				TX_SRC:
				begin
					link_serial_out <= tx_frame_src;
					tx_state <= TX_END;
				end
				TX_END:
				begin
					link_serial_out <= `LINE_IDLE;
					tx_ack_tgl <= ~tx_ack_tgl;
					tx_state <= TX_IDLE;
				end
				default:
				begin
					link_serial_out <= `LINE_IDLE;
					tx_state <= TX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge link_clock_in or negedge link_rst_b)
	begin
		if (!link_rst_b)
		begin
			rx_state <= RX_IDLE;
			rx_idx <= `FIRST_DATA_IDX;
			rx_shift <= `BYTE_RST;
			rx_word <= `BYTE_RST;
			rx_target_channel_bit <= `SRC_CHAN_A;
			rx_req_tgl <= `TGL_RST;
			rx_ack_seen <= `TGL_RST;
		end
		else
		begin
			case (rx_state)
				RX_IDLE:
				begin
					if (rx_accept)
					begin
						rx_idx <= `FIRST_DATA_IDX;
						rx_state <= RX_DATA;
					end
				end
				RX_DATA:
				begin
					rx_shift <= {link_serial_in, rx_shift[7:1]};
					rx_idx <= rx_idx + 3'h1;
					if (rx_idx == `LAST_DATA_IDX)
						rx_state <= RX_TARGET_CHANNEL_BIT;
				end
				RX_TARGET_CHANNEL_BIT:
				begin
					rx_target_channel_bit <= link_serial_in;
					rx_word <= rx_shift;
					rx_req_tgl <= ~rx_req_tgl;
					rx_state <= RX_WAIT;
				end
				RX_WAIT:
				begin
					if (rx_ack_sync != rx_ack_seen)
					begin
						rx_ack_seen <= rx_ack_sync;
						rx_state <= RX_IDLE;
					end
				end
				default:
					rx_state <= RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge link_clock_in or negedge link_rst_b)
	begin
		if (!link_rst_b)
			link_clear_to_send <= `CTS_RST;
		else if (rx_accept)
			link_clear_to_send <= 1'b0;
		else if (rx_state == RX_IDLE)
			link_clear_to_send <= run_sync;
		else
			link_clear_to_send <= 1'b0;
	end

	// Link-domain checks
	sequence s_tx_data;
		link_serial_out == tx_frame[0] ##1 link_serial_out == tx_frame[1] ##1
		link_serial_out == tx_frame[2] ##1 link_serial_out == tx_frame[3] ##1
		link_serial_out == tx_frame[4] ##1 link_serial_out == tx_frame[5] ##1
		link_serial_out == tx_frame[6] ##1 link_serial_out == tx_frame[7];
	endsequence

	property p_tx_start;
		@(posedge link_clock_in) disable iff (!link_rst_b) launch |=> !link_serial_out;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("start bit not low");

	property p_tx_lsb;
		@(posedge link_clock_in) disable iff (!link_rst_b) launch |=> ##1 s_tx_data;
	endproperty
	a_tx_lsb: assert property (p_tx_lsb) else $error("data bits out of order");

	property p_tx_src;
		@(posedge link_clock_in) disable iff (!link_rst_b) launch |-> ##10 (link_serial_out == tx_frame_src);
	endproperty
	a_tx_src: assert property (p_tx_src) else $error("source bit wrong");

	property p_frame_len;
		@(posedge link_clock_in) disable iff (!link_rst_b)
			launch |-> ##11 (link_serial_out && tx_state == TX_IDLE);
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame not ten bits");

	property p_no_tx_in_rx;
		@(posedge link_clock_in) disable iff (!link_rst_b)
			(tx_state == TX_IDLE && (rx_state == RX_DATA || rx_state == RX_TARGET_CHANNEL_BIT)) |=> tx_state == TX_IDLE;
	endproperty
	a_no_tx_in_rx: assert property (p_no_tx_in_rx) else $error("send began during receive");

	property p_cts_drop;
		@(posedge link_clock_in) disable iff (!link_rst_b)
			rx_accept |=> !link_clear_to_send [*8] ##1 !link_clear_to_send;
	endproperty
	a_cts_drop: assert property (p_cts_drop) else $error("clear-to-send not dropped");

	property p_cts_hold;
		@(posedge link_clock_in) disable iff (!link_rst_b)
			(rx_state == RX_WAIT && rx_ack_sync == rx_ack_seen) |=> !link_clear_to_send;
	endproperty
	a_cts_hold: assert property (p_cts_hold) else $error("clear-to-send rose early");

	property p_rx_lsb;
		@(posedge link_clock_in) disable iff (!link_rst_b)
			rx_accept |-> ##9 rx_shift == {$past(link_serial_in, 1), $past(link_serial_in, 2),
				$past(link_serial_in, 3), $past(link_serial_in, 4), $past(link_serial_in, 5),
				$past(link_serial_in, 6), $past(link_serial_in, 7), $past(link_serial_in, 8)};
	endproperty
	a_rx_lsb: assert property (p_rx_lsb) else $error("received byte misassembled");

	// System-domain checks
	property p_cfg_only_load;
		@(posedge clk_sys) disable iff (!rst_b) !cfg_load |=> $stable(chan_a_fast) && $stable(chan_b_fast);
	endproperty
	a_cfg_only_load: assert property (p_cfg_only_load) else $error("mode changed without load");

	property p_pins_b;
		@(posedge clk_sys) disable iff (!rst_b) (cfg_load && (cfg_a_fast || cfg_b_fast)) |=> link_pins_on_b;
	endproperty
	a_pins_b: assert property (p_pins_b) else $error("pins not on channel B");

	property p_hold_no_send;
		@(posedge clk_sys) disable iff (!rst_b) link_held |=> $stable(tx_req_tgl);
	endproperty
	a_hold_no_send: assert property (p_hold_no_send) else $error("send while held");

	property p_hold_accepts;
		@(posedge clk_sys) disable iff (!rst_b) (link_held && any_fast && !tx_full) |-> tx_ready;
	endproperty
	a_hold_accepts: assert property (p_hold_accepts) else $error("held link refused data");

	property p_disabled;
		@(posedge clk_sys) disable iff (!rst_b) !any_fast |-> !tx_ready && !link_pins_on_b;
	endproperty
	a_disabled: assert property (p_disabled) else $error("link active while disabled");

	property p_route_zero;
		@(posedge clk_sys) disable iff (!rst_b)
			(rx_new && !rx_target_channel_bit) |=> (chan_a_fast ? rx_a_valid : rx_b_valid);
	endproperty
	a_route_zero: assert property (p_route_zero) else $error("target zero misrouted");

	property p_route_one;
		@(posedge clk_sys) disable iff (!rst_b)
			(rx_new && rx_target_channel_bit) |=> (chan_b_fast ? rx_b_valid : rx_a_valid);
	endproperty
	a_route_one: assert property (p_route_one) else $error("target one misrouted");

endmodule

// ### iso_link_cfg.svh
// Constants for the isolated fast serial link block
`ifndef ISO_LINK_CFG_SVH
`define ISO_LINK_CFG_SVH

// Mode-select values written by the host driver
`define MODE_HOLD_VAL 8'h10
`define MODE_RUN_VAL 8'h00

// Line levels and frame layout
`define LINE_IDLE 1'b1
`define START_BIT 1'b0
`define SRC_CHAN_A 1'b0
`define SRC_CHAN_B 1'b1
`define LAST_DATA_IDX 3'h7
`define FIRST_DATA_IDX 3'h0

// Reset values
`define HOLD_RST 1'b0
`define FAST_EN_RST 1'b0
`define CTS_RST 1'b0
`define TGL_RST 1'b0
`define BYTE_RST 8'h00

`endif

// ### iso_link_pkg.sv
// Types shared by the isolated fast serial link block
package iso_link_pkg;

	typedef logic [7:0] byte_t;

	typedef enum logic [1:0]
	{
		TX_IDLE = 2'b00,
		TX_DATA = 2'b01,
		TX_SRC = 2'b10,
		TX_END = 2'b11
	} tx_state_e;

	typedef enum logic [1:0]
	{
		RX_IDLE = 2'b00,
		RX_DATA = 2'b01,
		RX_TARGET_CHANNEL_BIT = 2'b10,
		RX_WAIT = 2'b11
	} rx_state_e;

endpackage

// ### iso_link_far_end.sv
// Far-end device model: owns the link clock, sends and takes frames
`timescale 1ns/1ps

module iso_link_far_end
(
	// Link pins
	output logic link_clock_in,
	output logic link_serial_in,
	input wire logic link_serial_out,
	input wire logic link_clear_to_send
);
	logic cts_at_start;

	// Clock rests low outside frames; data line has a pull-up, so it idles high
	initial
	begin
		link_clock_in = 1'b0;
		link_serial_in = 1'b1;
		cts_at_start = 1'b1;
	end

	task automatic tick();
	begin
		#24 link_clock_in = 1'b1;
		#24 link_clock_in = 1'b0;
	end
	endtask

	task automatic send_frame(input logic [7:0] d, input logic target_channel_bit, output logic ok);
		logic [9:0] bits;
		int n;
	begin
		bits = {target_channel_bit, d, 1'b0};
		n = 0;
		while (link_clear_to_send !== 1'b1 && n < 40)
		begin
			tick();
			n++;
		end
		ok = link_clear_to_send;
		for (int i = 0; i < 10 && ok; i++)
		begin
			link_serial_in = bits[i];
			tick();
			if (i == 0)
				cts_at_start = link_clear_to_send;
		end
		link_serial_in = 1'b1;
	end
	endtask

	// Stall freezes the clock after the start bit, as a busy receiver would
	task automatic recv_frame(input int limit, input int stall, output logic [8:0] got, output logic ok);
		int n;
	begin
		ok = 1'b0;
		got = '0;
		for (n = 0; n < limit && !ok; n++)
		begin
			tick();
			ok = (link_serial_out === 1'b0);
		end
		if (ok)
		begin
			#(stall);
			for (int i = 0; i < 9; i++)
			begin
				tick();
				got[i] = link_serial_out;
			end
			repeat (2) tick();
		end
	end
	endtask
endmodule

// ### isolated_fast_serial_link_tb_top.sv
// Self-checking bench for the isolated fast serial link
`timescale 1ns/1ps
`include "iso_link_cfg.svh"

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end

module isolated_fast_serial_link_tb_top;
	import iso_link_pkg::*;

	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic cfg_load = 1'b0;
	logic cfg_a_fast = 1'b0;
	logic cfg_b_fast = 1'b0;
	logic mode_wr = 1'b0;
	logic [7:0] mode_val = 8'h00;
	logic tx_valid = 1'b0;
	logic tx_chan = 1'b0;
	logic rx_a_ready = 1'b0;
	logic rx_b_ready = 1'b0;
	byte_t tx_data = 8'h00;
	logic tx_ready, rx_a_valid, rx_b_valid, link_pins_on_b, link_held;
	byte_t rx_a_data, rx_b_data;
	logic link_clock_in, link_serial_in, link_serial_out, link_clear_to_send;
	int error_cnt = 0;
	int cmp_count = 0;
	logic ok;
	logic [8:0] got;
	logic [7:0] d;

	always #25 clk_sys = ~clk_sys;

	isolated_fast_serial_link dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .cfg_load(cfg_load),
		.cfg_a_fast(cfg_a_fast), .cfg_b_fast(cfg_b_fast), .mode_wr(mode_wr), .mode_val(mode_val),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_chan(tx_chan),
		.rx_a_valid(rx_a_valid), .rx_a_ready(rx_a_ready), .rx_a_data(rx_a_data),
		.rx_b_valid(rx_b_valid), .rx_b_ready(rx_b_ready), .rx_b_data(rx_b_data),
		.link_pins_on_b(link_pins_on_b), .link_held(link_held), .link_clock_in(link_clock_in),
		.link_serial_in(link_serial_in), .link_serial_out(link_serial_out),
		.link_clear_to_send(link_clear_to_send));

	iso_link_far_end far_u (.link_clock_in(link_clock_in), .link_serial_in(link_serial_in),
		.link_serial_out(link_serial_out), .link_clear_to_send(link_clear_to_send));

	task automatic step();
	begin
		@(posedge clk_sys);
		#2;
	end
	endtask

	task automatic end_of_test();
	begin
		$display("comparisons %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask

	// Routing the system side should show: 1 means channel B
	function automatic logic to_b(input logic target_channel_bit, input logic a, input logic b);
		return target_channel_bit ? b : ~a;
	endfunction

	// Link-side tasks leave the bench off the system clock's phase; realign first
	task automatic configure(input logic a, input logic b);
	begin
		step();
		cfg_a_fast = a;
		cfg_b_fast = b;
		cfg_load = 1'b1;
		step();
		cfg_load = 1'b0;
		// Stray level after the load must not change the routing
		cfg_a_fast = ~a;
		step();
		`CHK("pins_on_b", a | b, link_pins_on_b)
	end
	endtask

	task automatic set_mode(input logic [7:0] v);
	begin
		step();
		mode_val = v;
		mode_wr = 1'b1;
		step();
		mode_wr = 1'b0;
		step();
	end
	endtask

	task automatic tx_put(input logic [7:0] v, input logic ch);
		int n;
	begin
		step();
		n = 0;
		while (tx_ready !== 1'b1 && n < 200)
		begin
			step();
			n++;
		end
		`CHK("tx_ready", 1'b1, tx_ready)
		tx_data = v;
		tx_chan = ch;
		tx_valid = 1'b1;
		step();
		tx_valid = 1'b0;
	end
	endtask

	task automatic tx_check(input logic [7:0] v, input logic ch);
	begin
		tx_put(v, ch);
		far_u.recv_frame(30, ($urandom % 2) * 300, got, ok);
		`CHK("tx_frame", 1'b1, ok)
		`CHK("tx_data", v, got[7:0])
		`CHK("tx_src", ch, got[8])
	end
	endtask

	task automatic rx_check(input logic [7:0] v, input logic target_channel_bit, input logic a, input logic b);
		int n;
		logic ob;
	begin
		far_u.send_frame(v, target_channel_bit, ok);
		`CHK("rx_sent", 1'b1, ok)
		`CHK("cts_at_start", 1'b0, far_u.cts_at_start)
		ob = to_b(target_channel_bit, a, b);
		n = 0;
		while (!(rx_a_valid | rx_b_valid) && n < 20)
		begin
			step();
			n++;
		end
		`CHK("rx_route", {ob, ~ob}, {rx_b_valid, rx_a_valid})
		`CHK("rx_data", v, ob ? rx_b_data : rx_a_data)
		// Consumer holds off, so the link must keep refusing
		repeat (4) far_u.tick();
		`CHK("cts_held", 1'b0, link_clear_to_send)
		step();
		rx_a_ready = ~ob;
		rx_b_ready = ob;
		step();
		rx_a_ready = 1'b0;
		rx_b_ready = 1'b0;
	end
	endtask

	initial
	begin
		void'($urandom(73637));
		fork
			repeat (3) far_u.tick();
			repeat (6) step();
		join
		rst_b = 1'b1;
		`CHK("idle_out", `LINE_IDLE, link_serial_out)
		`CHK("off_tx_ready", 1'b0, tx_ready)
		far_u.recv_frame(12, 0, got, ok);
		`CHK("off_frame", 1'b0, ok)
		`CHK("off_cts", 1'b0, link_clear_to_send)
		for (int k = 1; k < 4; k++)
		begin
			configure(k[0], k[1]);
			tx_check(8'h01, 1'b0);
			tx_check(8'h80, 1'b1);
			for (int j = 0; j < 4; j++)
			begin
				d = 8'($urandom);
				tx_check(d, j[1]);
				rx_check(~d, j[0], k[0], k[1]);
			end
		end
		set_mode(8'h55);
		`CHK("ignored_mode", 1'b0, link_held)
		set_mode(`MODE_HOLD_VAL);
		`CHK("held", 1'b1, link_held)
		d = 8'($urandom);
		tx_put(d, 1'b1);
		far_u.recv_frame(20, 0, got, ok);
		`CHK("held_frame", 1'b0, ok)
		set_mode(`MODE_RUN_VAL);
		`CHK("run", 1'b0, link_held)
		far_u.recv_frame(30, 0, got, ok);
		`CHK("resumed", {2'b11, d}, {ok, got})
		configure(1'b0, 1'b0);
		`CHK("none_tx_ready", 1'b0, tx_ready)
		end_of_test();
	end

	// Whole run is some tens of microseconds; this bound only cuts a hang
	initial
	begin
		#2000000;
		error_cnt++;
		end_of_test();
	end
endmodule
